/* inc/peripheral_dma_map.vh */
// Purpose: register map, field positions and reset values of the peripheral dma channel pair
// Assumes: 32-bit avalon-mm word addressing in bytes, one register per aligned word
// Notes:   included by the channel and top design files of the block, not by the flag module
`ifndef PERIPHERAL_DMA_MAP_VH
`define PERIPHERAL_DMA_MAP_VH

// register byte offsets
`define OFS_RX_PTR      8'h00
`define OFS_RX_CNT      8'h04
`define OFS_TX_PTR      8'h08
`define OFS_TX_CNT      8'h0c
`define OFS_RX_NPTR     8'h10
`define OFS_RX_NCNT     8'h14
`define OFS_TX_NPTR     8'h18
`define OFS_TX_NCNT     8'h1c
`define OFS_CTRL        8'h20
`define OFS_STATUS      8'h24

// control and status bit positions
`define BIT_RX_EN       0
`define BIT_RX_DIS      1
`define BIT_TX_EN       8
`define BIT_TX_DIS      9

// widths and reset values
`define CNT_W           16
`define PTR_RST         32'h0000_0000
`define CNT_RST         16'h0000

// transfer size codes
`define SIZE_BYTE       2'h0
`define SIZE_HALF       2'h1
`define SIZE_WORD       2'h2

`endif

/* src/dma_channel.v */
// Purpose: one direction of the dma pair: pointer and counter with chaining
// Assumes: xfer_done pulses once per completed memory transfer
// Notes:   software writes take priority over the hardware update in the same cycle
`timescale 1ns/10ps
`default_nettype none
`include "peripheral_dma_map.vh"
module dma_channel (
    input  wire        clk,
    input  wire        srst,
    input  wire        wr_ptr,
    input  wire        wr_cnt,
    input  wire        wr_nptr,
    input  wire        wr_ncnt,
    input  wire [31:0] wdata,
    input  wire        xfer_done,
    input  wire [1:0]  xfer_size,
    output reg  [31:0] ptr_r,
    output reg  [15:0] cnt_r,
    output reg  [31:0] nptr_r,
    output reg  [15:0] ncnt_r
);

    // pointer step for the transfer size
    function [31:0] step;
        input [1:0] sz;
        begin
            case (sz)
                `SIZE_BYTE: step = 32'h0000_0001;
                `SIZE_HALF: step = 32'h0000_0002;
                default:    step = 32'h0000_0004;
            endcase
        end
    endfunction

    // a transfer landing on the last count leaves zero; the next buffer is loaded on the following edge
    wire [15:0] cnt_dec = cnt_r - 16'h0001;

    always @(posedge clk) begin
        if (srst) begin
            ptr_r  <= `PTR_RST;
            cnt_r  <= `CNT_RST;
            nptr_r <= `PTR_RST;
            ncnt_r <= `CNT_RST;
        end else begin
            if (wr_nptr)
                nptr_r <= wdata;
            if (wr_ncnt)
                ncnt_r <= wdata[15:0];
            if (wr_ptr)
                ptr_r <= wdata;
            if (wr_cnt)
                cnt_r <= wdata[15:0];
            if (!wr_ptr && !wr_cnt) begin
                if (xfer_done && cnt_r != `CNT_RST) begin
                    ptr_r <= ptr_r + step(xfer_size);
                    cnt_r <= cnt_dec;
                end else if (cnt_r == `CNT_RST && ncnt_r != `CNT_RST && !wr_ncnt) begin
                    ptr_r  <= nptr_r;
                    cnt_r  <= ncnt_r;
                    ncnt_r <= `CNT_RST;
                end
            end
        end
    end

endmodule // dma_channel
`default_nettype wire

/* src/dma_flags.v */
// Purpose: end-of-buffer and all-buffers flags of one direction
// Assumes: counters come straight from the channel registers
// Notes:   end flag is sticky until software rewrites a counter
`timescale 1ns/10ps
`default_nettype none
module dma_flags (
    input  wire        clk,
    input  wire        srst,
    input  wire [15:0] cnt,
    input  wire [15:0] ncnt,
    input  wire        cnt_wr,
    output reg         end_r,
    output reg         all_r
);

    // the reset value of zero counters raises the flags, as idle buffers are ended
    wire cnt_zero  = (cnt == 16'h0000);
    wire both_zero = cnt_zero && (ncnt == 16'h0000);
    // the clear acts a cycle after the write, once cnt holds the written value
    reg  cnt_wr_r;

    always @(posedge clk) begin
        if (srst) begin
            end_r    <= 1'b0;
            all_r    <= 1'b0;
            cnt_wr_r <= 1'b0;
        end else begin
            all_r    <= both_zero;
            cnt_wr_r <= cnt_wr;
            if (cnt_zero)
                end_r <= 1'b1;
            else if (cnt_wr_r)
                end_r <= 1'b0;
        end
    end

endmodule // dma_flags
`default_nettype wire

/* src/peripheral_dma.v */
// Purpose: register file and transfer control of a receive and a transmit dma channel
// Assumes: avalon-mm slave with waitrequest; peripheral ready inputs are synchronous
// Notes:   memory side is one request/ack port shared by both channels, receive first
//
// The implementer's own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "peripheral_dma_map.vh"
module peripheral_dma (
    input  wire        clk,
    input  wire        srst,
    // avalon-mm slave
    input  wire [7:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    input  wire [3:0]  byteenable,
    output reg  [31:0] readdata,
    output reg         waitrequest,
    output reg  [1:0]  response,
    // served peripheral
    input  wire        rx_ready,
    input  wire        tx_ready,
    input  wire [1:0]  xfer_size,
    output reg         rx_buffer_end_flag,
    output reg         tx_buffer_end_flag,
    output reg         rx_all_buffers_full_flag,
    output reg         tx_all_buffers_empty_flag,
    // memory transfer port
    output reg         mem_req,
    output reg         mem_dir_tx,
    output reg  [31:0] mem_addr,
    output reg  [1:0]  mem_size,
    input  wire        mem_ack
);

    // structure, in order below:
    //   bus phase state and the write strobes it qualifies
    //   byte-lane merge of write data
    //   two channel register sets with chaining
    //   end and all-buffers flags and their output flops
    //   request enables set through the control word
    //   one memory transfer engine shared by both directions
    //   the readback mux answering the bus
    // every output is a flop, so each result lags its cause
    // by at least one edge; the flags lag their counters by two

    // register map, byte offsets within the block:
    //   00 rx pointer        04 rx counter
    //   08 tx pointer        0c tx counter
    //   10 rx next pointer   14 rx next counter
    //   18 tx next pointer   1c tx next counter
    //   20 control, writes   24 status, reads
    // counters are 16 bits and read zero above

    // bus phase: idle, then one answer cycle with waitrequest low
    // the slave never stalls more than one cycle, so a master
    // holding its request sees exactly one wait state and may
    // start again in the cycle after the answer
    localparam ST_IDLE = 1'b0;
    localparam ST_ANS  = 1'b1;

    // busy stays set from a start to the edge seeing mem_ack
    // and covers both directions
    reg         bus_st_r;
    reg         bus_st_nxt;
    reg         rx_en_r;
    reg         tx_en_r;
    reg         busy_r;

    // taken only while idle; the answer cycle ignores the bus,
    // so a held request is never taken twice
    // unaligned addresses miss every register
    wire        acc      = (read || write) && bus_st_r == ST_IDLE;
    wire        wr_acc   = acc && write;
    wire [7:0]  wa       = address;

    // register decode, used only for the hit check of the response
    // status is mapped for reads; a write there is dropped
    function hit;
        input [7:0] a;
        begin
            case (a)
                `OFS_RX_PTR, `OFS_RX_CNT, `OFS_TX_PTR, `OFS_TX_CNT,
                `OFS_RX_NPTR, `OFS_RX_NCNT, `OFS_TX_NPTR, `OFS_TX_NCNT,
                `OFS_CTRL, `OFS_STATUS: hit = 1'b1;
                default:                hit = 1'b0;
            endcase
        end
    endfunction

    // partial byte enables are honoured by merging into the old word
    // counter words keep bits 15:0 only; the upper half
    // is never stored and reads back as zero
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  be;
        begin
            merge = {be[3] ? nw[31:24] : old[31:24], be[2] ? nw[23:16] : old[23:16],
                     be[1] ? nw[15:8]  : old[15:8],  be[0] ? nw[7:0]   : old[7:0]};
        end
    endfunction

    // channel registers, read by the bus and by the
    // transfer engine
    wire [31:0] rx_ptr;
    wire [15:0] rx_cnt;
    wire [31:0] rx_nptr;
    wire [15:0] rx_ncnt;
    wire [31:0] tx_ptr;
    wire [15:0] tx_cnt;
    wire [31:0] tx_nptr;
    wire [15:0] tx_ncnt;

    // one strobe per register, high in the taking cycle only;
    // status and unmapped offsets get none, so such writes
    // are dropped; only unmapped ones get a miss response
    wire wr_rx_ptr  = wr_acc && wa == `OFS_RX_PTR;
    wire wr_rx_cnt  = wr_acc && wa == `OFS_RX_CNT;
    wire wr_tx_ptr  = wr_acc && wa == `OFS_TX_PTR;
    wire wr_tx_cnt  = wr_acc && wa == `OFS_TX_CNT;
    wire wr_rx_nptr = wr_acc && wa == `OFS_RX_NPTR;
    wire wr_rx_ncnt = wr_acc && wa == `OFS_RX_NCNT;
    wire wr_tx_nptr = wr_acc && wa == `OFS_TX_NPTR;
    wire wr_tx_ncnt = wr_acc && wa == `OFS_TX_NCNT;
    wire wr_ctrl    = wr_acc && wa == `OFS_CTRL;

    // merged write data per target register
    // the merge needs the old value, taken from the channel
    // outputs of the same cycle; control passes straight
    // through
    reg  [31:0] wd_sel;
    always @* begin
        case (wa)
            `OFS_RX_PTR:  wd_sel = merge(rx_ptr, writedata, byteenable);
            `OFS_RX_CNT:  wd_sel = merge({16'h0000, rx_cnt}, writedata, byteenable);
            `OFS_TX_PTR:  wd_sel = merge(tx_ptr, writedata, byteenable);
            `OFS_TX_CNT:  wd_sel = merge({16'h0000, tx_cnt}, writedata, byteenable);
            `OFS_RX_NPTR: wd_sel = merge(rx_nptr, writedata, byteenable);
            `OFS_RX_NCNT: wd_sel = merge({16'h0000, rx_ncnt}, writedata, byteenable);
            `OFS_TX_NPTR: wd_sel = merge(tx_nptr, writedata, byteenable);
            `OFS_TX_NCNT: wd_sel = merge({16'h0000, tx_ncnt}, writedata, byteenable);
            default:      wd_sel = writedata;
        endcase
    end

    // memory transfer engine: receive is served ahead of transmit
    // a direction starts only while enabled, ready and with
    // count left; receive wins a tie, since a waiting receive
    // can be overrun by the next character while a late
    // transmit only idles the line
    wire rx_go = rx_en_r && rx_ready && rx_cnt != `CNT_RST;
    wire tx_go = tx_en_r && tx_ready && tx_cnt != `CNT_RST;
    wire done  = busy_r && mem_ack;
    wire rx_done = done && !mem_dir_tx;
    wire tx_done = done && mem_dir_tx;

    // receive channel: memory is written at its pointer,
    // stepped by the size latched at the start
    dma_channel u_rx (
        .clk       (clk),
        .srst      (srst),
        .wr_ptr    (wr_rx_ptr),
        .wr_cnt    (wr_rx_cnt),
        .wr_nptr   (wr_rx_nptr),
        .wr_ncnt   (wr_rx_ncnt),
        .wdata     (wd_sel),
        .xfer_done (rx_done),
        .xfer_size (mem_size),
        .ptr_r     (rx_ptr),
        .cnt_r     (rx_cnt),
        .nptr_r    (rx_nptr),
        .ncnt_r    (rx_ncnt)
    );

    // transmit channel: memory is read at its pointer
    dma_channel u_tx (
        .clk       (clk),
        .srst      (srst),
        .wr_ptr    (wr_tx_ptr),
        .wr_cnt    (wr_tx_cnt),
        .wr_nptr   (wr_tx_nptr),
        .wr_ncnt   (wr_tx_ncnt),
        .wdata     (wd_sel),
        .xfer_done (tx_done),
        .xfer_size (mem_size),
        .ptr_r     (tx_ptr),
        .cnt_r     (tx_cnt),
        .nptr_r    (tx_nptr),
        .ncnt_r    (tx_ncnt)
    );

    // flags lag the counters by one flop inside the flag
    // module and one at the output; the end flag is sticky,
    // so an idle channel with a zero counter keeps
    // reporting end of buffer
    wire rx_end;
    wire rx_all;
    wire tx_end;
    wire tx_all;

    // writing either receive counter clears its end flag, unless the rx counter is still zero in the cycle after the write
    dma_flags u_rx_flags (
        .clk    (clk),
        .srst   (srst),
        .cnt    (rx_cnt),
        .ncnt   (rx_ncnt),
        .cnt_wr (wr_rx_cnt || wr_rx_ncnt),
        .end_r  (rx_end),
        .all_r  (rx_all)
    );

    // the same for the transmit direction
    dma_flags u_tx_flags (
        .clk    (clk),
        .srst   (srst),
        .cnt    (tx_cnt),
        .ncnt   (tx_ncnt),
        .cnt_wr (wr_tx_cnt || wr_tx_ncnt),
        .end_r  (tx_end),
        .all_r  (tx_all)
    );

    // flags leave through their own flops so outputs come from registers
    // one more cycle of latency on every flag keeps the
    // status path of the peripheral free of decode logic
    always @(posedge clk) begin
        if (srst) begin
            rx_buffer_end_flag        <= 1'b0;
            tx_buffer_end_flag        <= 1'b0;
            rx_all_buffers_full_flag  <= 1'b0;
            tx_all_buffers_empty_flag <= 1'b0;
        end else begin
            rx_buffer_end_flag        <= rx_end;
            tx_buffer_end_flag        <= tx_end;
            rx_all_buffers_full_flag  <= rx_all;
            tx_all_buffers_empty_flag <= tx_all;
        end
    end

    // request enables; disable beats enable in the same write
    // each half acts only with its byte lane enabled; zero
    // bits leave the state alone, so software can touch one
    // direction without knowing the other
    always @(posedge clk) begin
        if (srst) begin
            rx_en_r <= 1'b0;
            tx_en_r <= 1'b0;
        end else if (wr_ctrl) begin
            if (byteenable[0]) begin
                if (writedata[`BIT_RX_DIS])
                    rx_en_r <= 1'b0;
                else if (writedata[`BIT_RX_EN])
                    rx_en_r <= 1'b1;
            end
            if (byteenable[1]) begin
                if (writedata[`BIT_TX_DIS])
                    tx_en_r <= 1'b0;
                else if (writedata[`BIT_TX_EN])
                    tx_en_r <= 1'b1;
            end
        end
    end

    // a start raises mem_req with address, direction and
    // size; all stand until the edge seeing mem_ack, where
    // the request drops and the channel steps pointer and
    // counter; the next start comes one edge later at best
    // a start skips a cycle with a register write taken,
    // so software never races a transfer start
    // one transfer in flight; request held until the memory acknowledges
    always @(posedge clk) begin
        if (srst) begin
            busy_r     <= 1'b0;
            mem_req    <= 1'b0;
            mem_dir_tx <= 1'b0;
            mem_addr   <= `PTR_RST;
            mem_size   <= `SIZE_BYTE;
        end else if (done) begin
            busy_r  <= 1'b0;
            mem_req <= 1'b0;
        end else if (!busy_r && (rx_go || tx_go) && !wr_acc) begin
            busy_r     <= 1'b1;
            mem_req    <= 1'b1;
            mem_dir_tx <= !rx_go;
            mem_addr   <= rx_go ? rx_ptr : tx_ptr;
            mem_size   <= xfer_size;
        end
    end

    // bus phase machine: every access answers after exactly one wait cycle
    // two states only; the default branch returns a
    // corrupted state to idle within one cycle
    always @* begin
        case (bus_st_r)
            ST_IDLE: bus_st_nxt = (read || write) ? ST_ANS : ST_IDLE;
            ST_ANS:  bus_st_nxt = ST_IDLE;
            default: bus_st_nxt = ST_IDLE;
        endcase
    end

    // read mux and answer; control reads zero, unmapped answers slave error
    // readdata and response hold until the next access;
    // writes refresh them too, with the value before
    // the write
    always @(posedge clk) begin
        if (srst) begin
            bus_st_r    <= ST_IDLE;
            waitrequest <= 1'b1;
            readdata    <= 32'h0000_0000;
            response    <= 2'h0;
        end else begin
            bus_st_r    <= bus_st_nxt;
            waitrequest <= !(bus_st_nxt == ST_ANS);
            if (acc) begin
                response <= hit(wa) ? 2'h0 : 2'h2;
                case (wa)
                    `OFS_RX_PTR:  readdata <= rx_ptr;
                    `OFS_RX_CNT:  readdata <= {16'h0000, rx_cnt};
                    `OFS_TX_PTR:  readdata <= tx_ptr;
                    `OFS_TX_CNT:  readdata <= {16'h0000, tx_cnt};
                    `OFS_RX_NPTR: readdata <= rx_nptr;
                    `OFS_RX_NCNT: readdata <= {16'h0000, rx_ncnt};
                    `OFS_TX_NPTR: readdata <= tx_nptr;
                    `OFS_TX_NCNT: readdata <= {16'h0000, tx_ncnt};
                    `OFS_STATUS:  readdata <= {23'h000000, tx_en_r, 7'h00, rx_en_r};
                    default:      readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // limitations: one transfer in flight for both
    // directions, so a busy transmit delays a waiting
    // receive by one transfer; a disable only blocks the
    // next start, so a requested transfer always completes;
    // the memory side has no error answer

endmodule // peripheral_dma
`default_nettype wire

/* verif/dma_checker_properties.sv */
// Purpose: port-level checks of the dma channel pair
// Assumes: single clock, srst synchronous active high, byte lanes all on
// Notes:   enables are mirrored from taken control writes; disable wins
`timescale 1ns/10ps
`default_nettype none
module dma_checker (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic [7:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic [1:0]  response,
    input wire logic        rx_buffer_end_flag,
    input wire logic        tx_buffer_end_flag,
    input wire logic        rx_all_buffers_full_flag,
    input wire logic        tx_all_buffers_empty_flag,
    input wire logic        mem_req,
    input wire logic        mem_dir_tx,
    input wire logic [31:0] mem_addr,
    input wire logic        mem_ack
);
    logic rx_en_r, tx_en_r;
    wire  ctl_wr = write && waitrequest && address == 8'h20;
    wire  answer = read && !waitrequest;
    // mirror of the request enables, updated at the taking edge
    always @(posedge clk) begin
        if (srst) begin
            rx_en_r <= 1'b0;
            tx_en_r <= 1'b0;
        end else if (ctl_wr) begin
            if (writedata[1] || writedata[0])
                rx_en_r <= !writedata[1];
            if (writedata[9] || writedata[8])
                tx_en_r <= !writedata[9];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    sequence taken_s; (read || write) && waitrequest; endsequence
    sequence answer_s; !waitrequest ##1 waitrequest; endsequence
    bus_answer_a: assert property (taken_s |=> answer_s)
        else $error("bus answer not a single cycle");
    status_bits_a: assert property (answer && address == 8'h24 |->
        readdata == {23'h0, tx_en_r, 7'h0, rx_en_r}) else $error("status bits wrong");
    start_enabled_a: assert property ($rose(mem_req) |->
        (mem_dir_tx ? $past(tx_en_r) : $past(rx_en_r))) else $error("start while disabled");
    req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
        else $error("memory request dropped or moved");
    req_drop_a: assert property (mem_req && mem_ack |=> !mem_req)
        else $error("memory request held after ack");
    all_flags_a: assert property ((!rx_all_buffers_full_flag || rx_buffer_end_flag) &&
        (!tx_all_buffers_empty_flag || tx_buffer_end_flag)) else $error("all flag without end");
    unmapped_read_a: assert property (answer && address > 8'h24 |-> response == 2'h2 &&
        readdata == 32'h0) else $error("unmapped read not refused");
    mapped_read_a: assert property (answer && address <= 8'h24 && address[1:0] == 2'h0 |->
        response == 2'h0) else $error("mapped read refused");
    count_upper_a: assert property (answer && address < 8'h20 && address[2:0] == 3'h4 |->
        readdata[31:16] == 16'h0) else $error("counter upper bits not zero");
endmodule // dma_checker
bind peripheral_dma dma_checker chk (.clk, .srst, .address, .read, .write, .writedata,
    .readdata, .waitrequest, .response, .rx_buffer_end_flag, .tx_buffer_end_flag,
    .rx_all_buffers_full_flag, .tx_all_buffers_empty_flag, .mem_req, .mem_dir_tx,
    .mem_addr, .mem_ack);
`default_nettype wire

/* verif/mem_partner.sv */
// Purpose: system memory stand-in answering the dma memory port
// Assumes: mem_req is a level held until acknowledged
// Notes:   delay sets idle cycles before each ack, stalling the engine
`timescale 1ns/10ps
`default_nettype none
module mem_partner (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       mem_req,
    input  wire logic [3:0] delay,
    output var  logic       mem_ack
);
    logic [3:0] wait_r;
    // ack is a one-cycle pulse, never given to an idle port
    always @(posedge clk) begin
        mem_ack <= 1'b0;
        if (srst) begin
            wait_r <= 4'h0;
        end else if (mem_req && !mem_ack) begin
            if (wait_r >= delay) begin
                mem_ack <= 1'b1;
                wait_r <= 4'h0;
            end else begin
                wait_r <= wait_r + 4'h1;
            end
        end
    end
endmodule // mem_partner
`default_nettype wire

/* verif/peripheral_dma_test.sv */
// Purpose: self-checking bench for the dma channel pair
// Assumes: slave answers one cycle after taking a request
// Notes:   reads and memory transfers are queued as expectations
`timescale 1ns/10ps
`default_nettype none
module peripheral_dma_test;
    logic        clk = 1'b0, srst = 1'b1, read = 1'b0, write = 1'b0;
    logic        rx_ready = 1'b0, tx_ready = 1'b0;
    logic [7:0]  address = 8'h00;
    logic [31:0] writedata = 32'h0;
    logic [1:0]  xfer_size = 2'h0;
    logic [3:0]  delay = 4'h0;
    wire  [31:0] readdata, mem_addr;
    wire  [1:0]  response, mem_size;
    wire  [3:0]  flags;
    wire         waitrequest, mem_req, mem_dir_tx, mem_ack;
    int          fail_count = 0, total_checks = 0;
    logic [33:0] rd_q[$];
    logic [34:0] mem_q[$];
    peripheral_dma dut (.clk, .srst, .address, .read, .write, .writedata, .byteenable(4'hf),
        .readdata, .waitrequest, .response, .rx_ready, .tx_ready, .xfer_size,
        .rx_buffer_end_flag(flags[0]), .tx_buffer_end_flag(flags[1]),
        .rx_all_buffers_full_flag(flags[2]), .tx_all_buffers_empty_flag(flags[3]),
        .mem_req, .mem_dir_tx, .mem_addr, .mem_size, .mem_ack);
    mem_partner mem (.clk, .srst, .mem_req, .delay, .mem_ack);
    initial forever #12.5 clk = ~clk;
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input logic [34:0] got, input logic [34:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one compare task per kind of result
    task automatic check_rd(input logic [33:0] got, input logic [33:0] exp);
        check({1'b0, got}, {1'b0, exp});
    endtask
    task automatic check_mem(input logic [34:0] got, input logic [34:0] exp);
        check(got, exp);
    endtask
    task automatic check_flags(input logic [1:0] got, input logic [1:0] exp);
        check({33'h0, got}, {33'h0, exp});
    endtask
    // holds the request until waitrequest is seen low, then releases
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        do
            @(posedge clk);
        while (waitrequest !== 1'b0);
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        rd_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    // results are matched to the oldest note as they appear
    always @(posedge clk) begin
        if (read && !waitrequest)
            check_rd({response, readdata}, rd_q.size() ? rd_q.pop_front() : 'x);
        if (mem_req && mem_ack)
            check_mem({mem_size, mem_dir_tx, mem_addr}, mem_q.size() ? mem_q.pop_front() : 'x);
    end
    // one chained buffer pair in one direction, with a slow or prompt memory
    task automatic run(input logic tx, input logic [1:0] sz);
        logic [15:0] c, nc;
        logic [31:0] p, np, en;
        logic [7:0]  b;
        logic [1:0]  sh;
        int          n;
        c = 16'($urandom_range(3, 0));
        sh = (sz == 2'h3) ? 2'h2 : sz; // size code 3 steps as a word
        nc = 16'($urandom_range(2, 0));
        p = $urandom;
        np = $urandom;
        b = tx ? 8'h08 : 8'h00;
        en = tx ? 32'h100 : 32'h001;
        xfer_size <= sz;
        delay <= 4'($urandom_range(3, 0));
        bus(1'b1, 8'h20, en * 3);
        rd(8'h24, 34'h0);
        bus(1'b1, b, p);
        bus(1'b1, b + 8'h04, {16'($urandom), c});
        bus(1'b1, b + 8'h10, np);
        bus(1'b1, b + 8'h14, {16'($urandom), nc});
        for (n = 0; n < c + nc; n++)
            mem_q.push_back({sz, tx, n < c ? p + (n << sh) : np + ((n - c) << sh)});
        rx_ready <= !tx;
        tx_ready <= tx;
        bus(1'b1, 8'h20, en);
        bus(1'b1, 8'h20, 32'h0);
        n = 0;
        while (mem_q.size() > 0 && n < 500) begin
            @(posedge clk);
            n++;
        end
        repeat (4) @(posedge clk);
        rd(8'h24, {2'h0, en});
        rd(b, nc ? np + (nc << sh) : p + (c << sh));
        rd(b + 8'h04, 34'h0);
        rd(b + 8'h14, 34'h0);
        check_flags(tx ? {flags[3], flags[1]} : {flags[2], flags[0]}, 2'h3);
        bus(1'b1, 8'h20, en * 2);
        rd(8'h24, 34'h0);
        bus(1'b1, b + 8'h04, 32'h5);
        repeat (2) @(posedge clk);
        check_flags(tx ? {flags[3], flags[1]} : {flags[2], flags[0]}, 2'h0);
        rd(b + 8'h04, 34'h5);
        rx_ready <= 1'b0;
        tx_ready <= 1'b0;
    endtask
    initial begin
        void'($urandom(32'hc789));
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 10; i++)
            rd(8'(i * 4), 34'h0);
        rd(8'h28, {2'h2, 32'h0});
        bus(1'b1, 8'h30, $urandom);
        rd(8'h30, {2'h2, 32'h0});
        for (int i = 0; i < 6; i++)
            run(i[0], 2'(i % 4));
        check(rd_q.size() + mem_q.size(), 35'h0);
        give_verdict();
    end
    // cuts a hang short well beyond the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        give_verdict();
    end
endmodule // peripheral_dma_test
`default_nettype wire
